//--- hw/adcrb_pkg.sv
// holds register offsets, field positions and reset values of the
// converter result-buffer sequencer.
// assumes a word-indexed plain register port of 8 address bits.
package adcrb_pkg;
   // ------------------------------------------------------------
   // register offsets (word index)
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL_ONE  = 8'h00; // converter_control_one
   localparam logic [7:0] OFS_CTRL_TWO  = 8'h01; // converter_control_two
   localparam logic [7:0] OFS_SCAN_LOW  = 8'h02; // scan_select_low
   localparam logic [7:0] OFS_STATUS    = 8'h03; // sticky events, w1c
   localparam logic [7:0] OFS_MASK      = 8'h04;
   localparam logic [7:0] OFS_DMA_ADDR  = 8'h05; // read only
   localparam logic [7:0] OFS_RESULT    = 8'h10; // result_entry_zero
   localparam logic [7:0] OFS_RESULT_LAST = 8'h1f; // result_entry_last
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int CTRL_ONE_DONE   = 0;
   localparam int CTRL_ONE_SAMPLE = 1;
   localparam int CTRL_ONE_BUSY   = 2;
   localparam int CTRL_TWO_SMPI_LO = 0;   // samples_per_interrupt [3:0]
   localparam int CTRL_TWO_SCAN   = 4;    // channel_scan_enable
   localparam int CTRL_TWO_DMA    = 5;    // dma_mode_select
   localparam int CTRL_TWO_CHAN_LO = 8;   // fixed channel [11:8]
   localparam int STAT_CONV_EVT   = 0;    // interrupt event
   localparam int STAT_DMA_EVT    = 1;    // dma pointer advanced
   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [15:0] RST_CTRL_TWO = 16'h0000;
   localparam logic [15:0] RST_SCAN_LOW = 16'h0001;
   localparam logic [1:0]  RST_MASK     = 2'h0;
   localparam logic [15:0] RST_DMA_ADDR = 16'h0000;
   // ------------------------------------------------------------
   // counts
   // ------------------------------------------------------------
   localparam int DMA_BURST = 32; // conversions per dma pointer step
   localparam int NUM_ENTRIES = 16;
   typedef enum logic [1:0] {
      ST_SAMPLE = 2'b01,
      ST_CONV   = 2'b10
   } adcrb_state_t;
endpackage : adcrb_pkg

//--- hw/adcrb_buf_if.sv
// carries the write and read ports between sequencer and result store.
// assumes one clock shared by both ends.
`timescale 1ns/1ps
interface adcrb_buf_if #(
   parameter int DW = 12,
   parameter int AW = 4
);
   logic          wr_en;
   logic [AW-1:0] wr_idx;
   logic [DW-1:0] wr_data;
   logic [AW-1:0] rd_idx;
   logic [DW-1:0] rd_data;
   modport seq   (output wr_en, wr_idx, wr_data, rd_idx, input rd_data);
   modport store (input wr_en, wr_idx, wr_data, rd_idx, output rd_data);
endinterface : adcrb_buf_if

//--- hw/adcrb_result_store.sv
// holds the sixteen result entries as flip-flops.
// assumes the sequencer gives one write per conversion at most.
`timescale 1ns/1ps
module adcrb_result_store
   import adcrb_pkg::*;
#(
   parameter int DW = 12,
   parameter int AW = 4
)(
   input  wire logic clk_in,
   input  wire logic sys_rst_in,
   adcrb_buf_if.store bus
);
   logic [DW-1:0] mem_q [2**AW];

   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   // entry chosen by index alone, never by converted channel
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         for (int i = 0; i < 2**AW; i++)
            mem_q[i] <= '0;
      end
      else if (bus.wr_en)
      begin
         mem_q[bus.wr_idx] <= bus.wr_data;
      end
   end

   assign bus.rd_data = mem_q[bus.rd_idx];
endmodule : adcrb_result_store

//--- hw/adcrb_seq.sv
// converter result sequencer: counts conversions, raises the interrupt,
// steps the scan list, writes results and steps the dma pointer.
// assumes conversion start, done and result come from same-clock logic.
//
// What this block does
// - set interrupt flag after samples_per_interrupt plus one conversions complete
// - scan enabled: restart scan list from first entry at that boundary
// - dma mode off: wrap result write pointer to entry zero at boundary
// - dma mode on: write entry zero only, step dma pointer every 32nd
// - dma mode off: samples_per_interrupt plus one entries filled in sequential order from entry zero
// - entry chosen by write pointer only, never by converted channel
// - done flag cleared at conversion start, set on completion, held
`timescale 1ns/1ps
module adcrb_seq
   import adcrb_pkg::*;
#(
   parameter int DW = 12
)(
   input  wire logic        clk_in,
   input  wire logic        sys_rst_in,
   input  wire logic [7:0]  addr_in,
   input  wire logic [15:0] wr_data_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   input  wire logic        conv_start_in,
   input  wire logic        conv_done_in,
   input  wire logic [DW-1:0] conv_result_in,
   output logic [15:0]      rd_data_out,
   output logic             irq_out,
   output logic             sample_out,
   output logic [3:0]       chan_sel_out,
   output logic             dma_req_out,
   output logic [15:0]      dma_addr_out
);
   import adcrb_pkg::*;

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   adcrb_state_t  state_q;
   logic          done_q;
   logic [15:0]   ctrl_two_q;
   logic [15:0]   scan_low_q;
   logic [1:0]    status_q;
   logic [1:0]    mask_q;
   logic [3:0]    cnt_q;
   logic [3:0]    wptr_q;
   logic [4:0]    dma_cnt_q;
   logic [3:0]    chan_q;
   logic          sample_start_bit_q;
   logic [15:0]   dma_addr_q;
   logic [15:0]   rdata_q;
   logic          irq_q;
   logic          dma_req_q;
   logic [3:0]    smpi;
   logic          scan_en;
   logic          dma_mode;
   logic          boundary;
   logic          dma_step;
   logic          wr_hit;
   logic [1:0]    evt_set;

   adcrb_buf_if #(.DW(DW), .AW(4)) buf_if ();

   adcrb_result_store #(.DW(DW), .AW(4)) u_store (
      .clk_in     (clk_in),
      .sys_rst_in (sys_rst_in),
      .bus        (buf_if.store)
   );

   assign smpi     = ctrl_two_q[CTRL_TWO_SMPI_LO +: 4];
   assign scan_en  = ctrl_two_q[CTRL_TWO_SCAN];
   assign dma_mode = ctrl_two_q[CTRL_TWO_DMA];
   // field n gives n+1 conversions per boundary
   assign boundary = conv_done_in && (cnt_q == smpi);
   assign dma_step = conv_done_in && dma_mode
                     && (dma_cnt_q == 5'(DMA_BURST - 1));
   assign evt_set  = {dma_step, boundary};

   // next enabled channel after cur, wrapping; lowest set bit if from=15
   function automatic logic [3:0] next_chan(input logic [15:0] sel,
                                            input logic [4:0]  from);
      logic [3:0] res;
      logic       hit;
      res = 4'h0;
      hit = 1'b0;
      for (int i = 0; i < 32; i++)
      begin
         if (!hit && (i > int'(from)) && sel[i % 16])
         begin
            res = 4'(i % 16);
            hit = 1'b1;
         end
      end
      return res;
   endfunction : next_chan

   // ------------------------------------------------------------
   // conversion phase tracking
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         state_q <= ST_SAMPLE;
      else
         case (state_q)
            ST_SAMPLE: if (conv_start_in) state_q <= ST_CONV;
            ST_CONV:   if (conv_done_in)  state_q <= ST_SAMPLE;
            default:   state_q <= ST_SAMPLE;
         endcase
   end

   // done: completion wins over a software clear in the same cycle
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         done_q <= 1'b0;
      else if (conv_done_in)
         done_q <= 1'b1;
      else if (conv_start_in)
         done_q <= 1'b0;
      else if (wr_in && addr_in == OFS_CTRL_ONE
               && !wr_data_in[CTRL_ONE_DONE])
         done_q <= 1'b0;
   end

   // sample start: set by software, ended when conversion starts
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         sample_start_bit_q <= 1'b0;
      else if (conv_start_in)
         sample_start_bit_q <= 1'b0;
      else if (wr_in && addr_in == OFS_CTRL_ONE)
         sample_start_bit_q <= wr_data_in[CTRL_ONE_SAMPLE];
   end

   // ------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         ctrl_two_q <= RST_CTRL_TWO;
         scan_low_q <= RST_SCAN_LOW;
         mask_q     <= RST_MASK;
      end
      else if (wr_in)
      begin
         if (addr_in == OFS_CTRL_TWO) ctrl_two_q <= wr_data_in;
         if (addr_in == OFS_SCAN_LOW) scan_low_q <= wr_data_in;
         if (addr_in == OFS_MASK)     mask_q     <= wr_data_in[1:0];
      end
   end

   // ------------------------------------------------------------
   // sequencing counters
   // ------------------------------------------------------------
   // conversion count: restarts at each boundary and on a rewrite of the
   // field, so a smaller field never strands the count above it
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         cnt_q <= 4'h0;
      else if (wr_in && addr_in == OFS_CTRL_TWO)
         cnt_q <= 4'h0;
      else if (boundary)
         cnt_q <= 4'h0;
      else if (conv_done_in)
         cnt_q <= cnt_q + 4'h1;
   end

   // write pointer: sequential, wraps at boundary, held at zero in dma
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         wptr_q <= 4'h0;
      else if (dma_mode)
         wptr_q <= 4'h0;
      else if (boundary)
         wptr_q <= 4'h0;
      else if (conv_done_in)
         wptr_q <= wptr_q + 4'h1;
   end

   // dma sample count and address pointer
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         dma_cnt_q  <= 5'h00;
         dma_addr_q <= RST_DMA_ADDR;
      end
      else if (conv_done_in && dma_mode)
      begin
         dma_cnt_q <= dma_cnt_q + 5'h01;          // wraps after 32
         if (dma_step)
            dma_addr_q <= dma_addr_q + 16'h0001;
      end
   end

   // scan channel: restarts at the first selected entry on boundary
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         chan_q <= 4'h0;
      else if (!scan_en)
         chan_q <= ctrl_two_q[CTRL_TWO_CHAN_LO +: 4];
      else if (boundary)
         chan_q <= next_chan(scan_low_q, 5'h0f);
      else if (conv_done_in)
         chan_q <= next_chan(scan_low_q, {1'b0, chan_q});
   end

   // ------------------------------------------------------------
   // result store port
   // ------------------------------------------------------------
   // in dma mode the single entry is overwritten each conversion,
   // so an unread result is lost
   assign buf_if.wr_en   = conv_done_in;
   assign buf_if.wr_idx  = dma_mode ? 4'h0 : wptr_q;
   assign buf_if.wr_data = conv_result_in;
   assign buf_if.rd_idx  = addr_in[3:0];

   // ------------------------------------------------------------
   // events and interrupt
   // ------------------------------------------------------------
   // set wins over a write-one clear in the same cycle
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         status_q <= 2'h0;
      else if (wr_in && addr_in == OFS_STATUS)
         status_q <= (status_q & ~wr_data_in[1:0]) | evt_set;
      else
         status_q <= status_q | evt_set;
   end

   // level output lags the status bits by one cycle
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         irq_q     <= 1'b0;
         dma_req_q <= 1'b0;
      end
      else
      begin
         irq_q     <= |(status_q & mask_q);
         dma_req_q <= conv_done_in && dma_mode;
      end
   end

   // ------------------------------------------------------------
   // read port
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
         rdata_q <= 16'h0000;
      else if (rd_in)
      begin
         rdata_q <= 16'h0000;                     // unmapped reads zero
         case (addr_in)
            OFS_CTRL_ONE: rdata_q <= {13'h0000, state_q == ST_CONV,
                                      sample_start_bit_q, done_q};
            OFS_CTRL_TWO: rdata_q <= ctrl_two_q;
            OFS_SCAN_LOW: rdata_q <= scan_low_q;
            OFS_STATUS:   rdata_q <= {14'h0000, status_q};
            OFS_MASK:     rdata_q <= {14'h0000, mask_q};
            OFS_DMA_ADDR: rdata_q <= dma_addr_q;
            default:
               if (addr_in >= OFS_RESULT && addr_in <= OFS_RESULT_LAST)
                  rdata_q <= 16'(buf_if.rd_data);
         endcase
      end
   end

   assign rd_data_out  = rdata_q;
   assign irq_out      = irq_q;
   assign sample_out   = sample_start_bit_q;
   assign chan_sel_out = chan_q;
   assign dma_req_out  = dma_req_q;
   assign dma_addr_out = dma_addr_q;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);

   sequence done_cause_s;
      conv_done_in;
   endsequence
   sequence boundary_s;
      conv_done_in && cnt_q == smpi;
   endsequence

   irq_flag_a: assert property (
      boundary_s |=> status_q[STAT_CONV_EVT])
      else $error("interrupt flag not set at boundary");
   irq_level_a: assert property (
      status_q[0] && mask_q[0] |=> irq_q)
      else $error("interrupt output not raised");
   scan_restart_a: assert property (
      boundary_s and scan_en |=> chan_q == next_chan(scan_low_q, 5'h0f))
      else $error("scan list did not restart");
   wptr_wrap_a: assert property (
      boundary_s and !dma_mode |=> wptr_q == 4'h0)
      else $error("write pointer did not wrap");
   dma_entry_a: assert property (
      dma_mode |-> buf_if.wr_idx == 4'h0)
      else $error("dma mode wrote beyond entry zero");
   dma_step_a: assert property (
      dma_step |=> dma_addr_q == $past(dma_addr_q) + 16'h0001)
      else $error("dma pointer did not advance");
   wptr_seq_a: assert property (
      done_cause_s and (!dma_mode && !boundary)
      |=> wptr_q == $past(wptr_q) + 4'h1)
      else $error("write pointer not sequential");
   done_set_a: assert property (
      done_cause_s |=> done_q)
      else $error("done flag not set on completion");
   done_clr_a: assert property (
      conv_start_in && !conv_done_in |=> !done_q)
      else $error("done flag not cleared at start");
   cnt_limit_a: assert property (
      cnt_q <= smpi || $changed(smpi))
      else $error("conversion count passed boundary");
endmodule : adcrb_seq

//--- tb/adcrb_dma_reader.sv
// behavioural dma reader that fetches entry zero after each request.
// assumes the bench gives it the register port while dma mode is run.
`timescale 1ns/1ps
module adcrb_dma_reader
   import adcrb_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        sys_rst_in,
   input  wire logic        dma_req_in,
   input  wire logic [15:0] rd_data_in,
   output logic             rd_out,
   output logic [7:0]       addr_out,
   output logic [15:0]      last_out,
   output logic [7:0]       count_out
);
   import adcrb_pkg::*;
   logic got_q;
   // ---------------------------------------------------------------
   // fetch the single result right after the request, well before the
   // next completion, so nothing is lost to the overwrite
   // ---------------------------------------------------------------
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         rd_out    <= 1'b0;
         got_q     <= 1'b0;
         last_out  <= 16'h0000;
         count_out <= 8'h00;
      end
      else
      begin
         rd_out <= dma_req_in;
         got_q  <= rd_out;
         if (got_q)
         begin
            last_out  <= rd_data_in;
            count_out <= count_out + 8'h01;
         end
      end
   end
   // address only valid with the strobe; inverse pattern otherwise
   assign addr_out = rd_out ? OFS_RESULT : ~OFS_RESULT;
endmodule : adcrb_dma_reader

//--- tb/tb_adc_result_buffer_sequencer.sv
// self-checking bench of the result sequencer with a dma reader model.
// assumes the reader owns the register port only during the dma run.
`timescale 1ns/1ps
module tb_adc_result_buffer_sequencer;
   import adcrb_pkg::*;
   logic clk_in = 1'b0, sys_rst_in = 1'b1, wr_in = 1'b0, b_rd = 1'b0;
   logic conv_start_in = 1'b0, conv_done_in = 1'b0;
   logic [7:0]  b_addr = 8'h00;
   logic [15:0] wr_data_in = 16'h0000;
   logic [11:0] conv_result_in = 12'h000;
   logic [15:0] rd_data_out, dma_addr_out, p_last;
   logic irq_out, sample_out, dma_req_out, p_rd;
   logic [3:0]  chan_sel_out;
   logic [7:0]  p_addr, p_count;
   int miscompares = 0, checks = 0;
   logic [15:0] v;
   // ---------------------------------------------------------------
   // clock, devices
   // ---------------------------------------------------------------
   initial forever #5 clk_in = ~clk_in;
   adcrb_seq #(.DW(12)) i_adcrb_seq (.clk_in(clk_in),
      .sys_rst_in(sys_rst_in), .addr_in(p_rd ? p_addr : b_addr),
      .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(b_rd | p_rd),
      .conv_start_in(conv_start_in), .conv_done_in(conv_done_in),
      .conv_result_in(conv_result_in), .rd_data_out(rd_data_out),
      .irq_out(irq_out), .sample_out(sample_out),
      .chan_sel_out(chan_sel_out), .dma_req_out(dma_req_out),
      .dma_addr_out(dma_addr_out));
   adcrb_dma_reader i_adcrb_dma_reader (.clk_in(clk_in),
      .sys_rst_in(sys_rst_in), .dma_req_in(dma_req_out),
      .rd_data_in(rd_data_out), .rd_out(p_rd), .addr_out(p_addr),
      .last_out(p_last), .count_out(p_count));
   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input string n, input logic [15:0] s, e);
      checks++;
      if (s !== e)
      begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_in);
      wr_in <= 1'b1; b_addr <= a; wr_data_in <= d;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask : wr
   // read data stands from the cycle after the strobe until the next read
   task automatic rd(input logic [7:0] a);
      @(posedge clk_in);
      b_rd <= 1'b1; b_addr <= a;
      @(posedge clk_in);
      b_rd <= 1'b0;
      #1 v = rd_data_out;
   endtask : rd
   task automatic conv(input logic [11:0] r);
      @(posedge clk_in);
      conv_start_in <= 1'b1;
      @(posedge clk_in);
      conv_start_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      conv_done_in <= 1'b1; conv_result_in <= r;
      @(posedge clk_in);
      conv_done_in <= 1'b0; conv_result_in <= ~r;
      repeat (3) @(posedge clk_in);
   endtask : conv
   task automatic give_verdict;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : give_verdict
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic reset_values;
      rd(OFS_CTRL_TWO);  chk("ctrl two", v, RST_CTRL_TWO);
      rd(OFS_SCAN_LOW);  chk("scan low", v, RST_SCAN_LOW);
      rd(OFS_STATUS);    chk("status", v, 16'h0000);
      rd(OFS_DMA_ADDR);  chk("dma addr", v, RST_DMA_ADDR);
      rd(8'h0f);         chk("unmapped", v, 16'h0000);
   endtask : reset_values
   // four conversions per boundary, fifth wraps to entry zero
   task automatic fill_and_wrap;
      int i, n;
      wr(OFS_SCAN_LOW, 16'h0005);
      wr(OFS_CTRL_TWO, 16'h0013);
      for (i = 0; i < 3; i++) conv(12'ha00 + 12'(i));
      chk("scan step", {12'h000, chan_sel_out}, 16'h0002);
      rd(OFS_STATUS); chk("early status", v, 16'h0000);
      conv(12'ha03);
      chk("scan restart", {12'h000, chan_sel_out}, 16'h0000);
      rd(OFS_STATUS); chk("boundary", v, 16'h0001);
      chk("masked irq", {15'h0, irq_out}, 16'h0000);
      wr(OFS_MASK, 16'h0001);
      n = 0;
      while (irq_out !== 1'b1 && n < 5)
      begin
         @(posedge clk_in);
         n++;
      end
      chk("irq", {15'h0, irq_out}, 16'h0001);
      wr(OFS_STATUS, 16'h0001);
      repeat (2) @(posedge clk_in);
      chk("irq clear", {15'h0, irq_out}, 16'h0000);
      conv(12'ha04);
      rd(OFS_RESULT); chk("wrap entry", v, 16'h0a04);
      for (i = 1; i < 4; i++)
      begin
         rd(OFS_RESULT + 8'(i));
         chk("entry", v, 16'h0a00 + 16'(i));
      end
   endtask : fill_and_wrap
   // single entry in dma mode; pointer steps on the 32nd result
   task automatic dma_run;
      int i;
      wr(OFS_CTRL_TWO, 16'h0020);
      for (i = 0; i < 31; i++) conv(12'h100 + 12'(i));
      chk("no step", dma_addr_out, RST_DMA_ADDR);
      conv(12'h11f);
      // the reader latches on the edge that conv returns on: let it land
      @(posedge clk_in);
      chk("step", dma_addr_out, RST_DMA_ADDR + 16'h0001);
      chk("reader", p_last, 16'h011f);
      chk("reads", {8'h00, p_count}, 16'h0020);
      rd(OFS_RESULT + 8'h01); chk("entry one", v, 16'h0a01);
      rd(OFS_STATUS); chk("dma event", v & 16'h0002, 16'h0002);
   endtask : dma_run
   // done flag set on completion, held, cleared by start or software
   task automatic done_flag;
      @(posedge clk_in);
      conv_start_in <= 1'b1;
      @(posedge clk_in);
      conv_start_in <= 1'b0;
      rd(OFS_CTRL_ONE); chk("done at start", v & 16'h0001, 16'h0000);
      @(posedge clk_in);
      conv_done_in <= 1'b1;
      @(posedge clk_in);
      conv_done_in <= 1'b0;
      repeat (6) @(posedge clk_in);
      rd(OFS_CTRL_ONE); chk("done held", v & 16'h0001, 16'h0001);
      wr(OFS_CTRL_ONE, 16'h0002);
      rd(OFS_CTRL_ONE); chk("sw clear", v & 16'h0003, 16'h0002);
      chk("sample", {15'h0, sample_out}, 16'h0001);
      conv(12'h055);
      chk("sample end", {15'h0, sample_out}, 16'h0000);
      rd(OFS_CTRL_ONE); chk("done again", v & 16'h0001, 16'h0001);
   endtask : done_flag
   // ---------------------------------------------------------------
   // main sequence and hang guard
   // ---------------------------------------------------------------
   initial
   begin
      repeat (2) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      reset_values();
      fill_and_wrap();
      dma_run();
      done_flag();
      give_verdict();
   end
   initial
   begin
      #500us;
      miscompares++;
      give_verdict();
   end
endmodule : tb_adc_result_buffer_sequencer
